// >>> tb/dpsc_asserts.sv
// port checks of the drive power state control top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module dpsc_asserts (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // object bus
   input wire logic        obj_wr,
   input wire logic        obj_rd,
   input wire logic [15:0] obj_index,
   input wire logic        obj_ack,
   input wire logic        obj_err,
   // drive side
   input wire logic        special_mode,
   input wire logic        bus_synced,
   input wire logic        quick_stop_active,
   input wire logic [15:0] state_report
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!reset_n);
   // state field; bits 6 and 5 are taken separately
   wire logic [3:0] st_low = state_report[3:0];

   a_ack_follows: assert property ((obj_wr || obj_rd) |=> obj_ack)
      else $error("no ack one cycle after a strobe");
   a_no_stray: assert property (!(obj_wr || obj_rd) |=> !obj_ack)
      else $error("ack without a strobe");
   a_ro_refused: assert property (
      (obj_wr && obj_index == 16'h6041) |=> obj_err)
      else $error("status word write not refused");
   a_cmd_taken: assert property (
      (obj_wr && obj_index == 16'h6040) |=> (obj_ack && !obj_err))
      else $error("command word write refused");
   a_remote_one: assert property (
      (!special_mode)[*3] |=> state_report[9])
      else $error("remote bit low outside special modes");
   a_remote_zero: assert property (
      special_mode[*3] |=> !state_report[9])
      else $error("remote bit high in special mode");
   a_sync_bit: assert property (
      $stable(bus_synced)[*3] |=> (state_report[8] == $past(bus_synced)))
      else $error("sync bit does not follow the bus");
   a_cla_enabled: assert property (
      state_report[15] |-> (state_report[6:5] == 2'b01 && st_low == 4'h7))
      else $error("closed loop flag outside operation enabled");
   a_sod_code: assert property (state_report[6] |-> st_low == 4'h0)
      else $error("switch-on disabled with bad low bits");
   a_legal_code: assert property (
      st_low inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'h8})
      else $error("state field holds no legal code");
   a_qstop_state: assert property (
      (state_report[6:5] == 2'b00 && st_low == 4'h7)
      |-> $past(quick_stop_active))
      else $error("quick stop code without quick stop state");
endmodule

bind dpsc_top dpsc_asserts chk_u (.clk, .reset_n, .obj_wr, .obj_rd,
   .obj_index, .obj_ack, .obj_err, .special_mode, .bus_synced,
   .quick_stop_active, .state_report);

// >>> tb/dpsc_master_model.sv
// fieldbus master model issuing single object accesses
// assumes a one-cycle strobe answered by ack one cycle later
`timescale 1ns/10ps
module dpsc_master_model (
   // clock
   input wire logic        clk,
   // requests
   output logic            obj_wr,
   output logic            obj_rd,
   output logic [15:0]     obj_index,
   output logic [7:0]      obj_sub,
   output logic [31:0]     obj_wdata,
   // answers
   input wire logic [31:0] obj_rdata,
   input wire logic        obj_ack,
   input wire logic        obj_err
);
   initial begin
      obj_wr = 1'b0;
      obj_rd = 1'b0;
      obj_index = 16'h0;
      obj_sub = 8'h0;
      obj_wdata = 32'h0;
   end

   // whole words only; idle lines scrambled so stale values never help
   task automatic access(input logic wr, input logic [15:0] idx,
         input logic [7:0] sub, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      #1;
      obj_wr = wr;
      obj_rd = !wr;
      obj_index = idx;
      obj_sub = sub;
      obj_wdata = wd;
      @(posedge clk);
      #1;
      obj_wr = 1'b0;
      obj_rd = 1'b0;
      obj_index = ~idx;
      obj_sub = ~sub;
      obj_wdata = ~wd;
      n = 0;
      while (obj_ack !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      rd = obj_rdata;
      err = obj_err;
   endtask
endmodule

// >>> tb/dpsc_top_tb.sv
// self-checking bench of the drive power state control block
// assumes the master model drives the object bus
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module dpsc_top_tb;
   logic clk, reset_n, obj_wr, obj_rd, obj_ack, obj_err, er;
   logic [15:0] obj_index, fault_code, error_code, state_report, w, c;
   logic [15:0] mn, mx;
   logic [7:0] obj_sub, op_mode;
   logic [31:0] obj_wdata, obj_rdata, rd;
   logic special_mode, bus_synced, closed_loop, fault_event, warn_event;
   logic reaction_done, goal_reached, init_done, power_enable;
   logic drive_enable, quick_stop_active, halt_active;
   logic signed [15:0] speed_measured, speed_demand;
   logic [3:0] mode_dependent_bits;
   logic [7:0] modes [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                             8'h07, 8'h06};
   int mismatches, n_checks, cycles, k;

   dpsc_top #(.WIDTH(16)) dut_u (.clk, .reset_n, .obj_wr, .obj_rd,
      .obj_index, .obj_sub, .obj_wdata, .obj_rdata, .obj_ack, .obj_err,
      .op_mode, .special_mode, .bus_synced, .closed_loop, .fault_event,
      .fault_code, .warn_event, .reaction_done, .goal_reached, .init_done,
      .speed_measured, .power_enable, .drive_enable, .quick_stop_active,
      .halt_active, .mode_dependent_bits, .speed_demand, .error_code,
      .state_report);
   dpsc_master_model pm_u (.clk, .obj_wr, .obj_rd, .obj_index, .obj_sub,
      .obj_wdata, .obj_rdata, .obj_ack, .obj_err);

   always #50 clk = ~clk;
   // hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end

   function automatic logic [31:0] sx(input logic [15:0] x);
      return {{16{x[15]}}, x};
   endfunction
   function automatic logic [15:0] clamp(input logic [15:0] t);
      if ($signed(t) < $signed(mn)) return mn;
      if ($signed(t) > $signed(mx)) return mx;
      return t;
   endfunction
   function automatic logic halt_exp(input logic [7:0] m, input logic b);
      return b && (m inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h07});
   endfunction
   function automatic logic [3:0] omb_exp(input logic [7:0] m);
      return (m == 8'h00) ? 4'h0 : {w[9], w[6:4]};
   endfunction

   task automatic wr(input logic [15:0] i, input logic [7:0] s,
         input logic [31:0] d);
      pm_u.access(1'b1, i, s, d, rd, er);
   endtask
   task automatic rdc(input logic [15:0] i, input logic [7:0] s,
         input logic [31:0] e);
      pm_u.access(1'b0, i, s, 32'h0, rd, er);
      `CHK(rd, e)
   endtask
   // state changes lag the command by two cycles, the report by one more
   task automatic wt();
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic st(input logic [15:0] code);
      wt();
      `CHK(state_report & 16'h006F, code)
   endtask
   task automatic trip(input logic [15:0] code);
      fault_code = code;
      fault_event = 1'b1;
      @(posedge clk);
      #1;
      fault_event = 1'b0;
      st(16'h000F);
      reaction_done = 1'b1;
      wt();
      reaction_done = 1'b0;
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      {op_mode, bus_synced, closed_loop, init_done, warn_event} = '0;
      {fault_event, fault_code, reaction_done} = '0;
      special_mode = 1'b1;
      w = 16'($urandom(32'h0526));
      goal_reached = w[0];
      speed_measured = 16'($urandom);
      repeat (16) @(posedge clk);
      #1;
      `CHK(state_report, 16'h0000)
      reset_n = 1'b1;
      // target-reached bit follows its input even straight after reset
      rdc(16'h6041, 8'h00, {21'h0, goal_reached, 10'h0});
      rdc(16'h6040, 8'h00, 32'h0);
      rdc(16'h6042, 8'h00, 32'h000000C8);
      rdc(16'h6043, 8'h00, 32'h0);
      rdc(16'h6044, 8'h00, sx(speed_measured));
      rdc(16'h6046, 8'h00, 32'h2);
      rdc(16'h6046, 8'h01, 32'h0);
      rdc(16'h6046, 8'h02, 32'h7530);
      wr(16'h6041, 8'h00, 32'hFFFF);
      `CHK(er, 1'b1)
      wr(16'h6043, 8'h00, 32'h1234);
      `CHK(er, 1'b1)
      rdc(16'h6041, 8'h00, {21'h0, goal_reached, 10'h0});
      done("registers");
      for (k = 0; k < 8; k++) begin
         op_mode = modes[k];
         w = 16'($urandom);
         w[8] = k[0];
         wr(16'h6040, 8'h00, {16'h0, w});
         `CHK(halt_active, halt_exp(op_mode, w[8]))
         `CHK(mode_dependent_bits, omb_exp(op_mode))
         rdc(16'h6040, 8'h00, {16'h0, w});
         w = 16'($urandom);
         wr(16'h6042, 8'h00, {16'h0, w});
         rdc(16'h6042, 8'h00, sx(w));
      end
      done("modes");
      wr(16'h6040, 8'h00, 32'h0);
      special_mode = 1'b0;
      bus_synced = 1'b1;
      init_done = 1'b1;
      st(16'h0040);
      `CHK(power_enable, 1'b0)
      `CHK(state_report[9:8], 2'b11)
      mn = 16'(50 + $urandom % 100);
      mx = 16'(1000 + $urandom % 1000);
      wr(16'h6046, 8'h01, {16'h0, mn});
      wr(16'h6046, 8'h02, {16'h0, mx});
      rdc(16'h6046, 8'h01, {16'h0, mn});
      wr(16'h6040, 8'h00, 32'h0006);
      st(16'h0021);
      `CHK(power_enable, 1'b1)
      wr(16'h6040, 8'h00, 32'h0007);
      st(16'h0023);
      closed_loop = 1'b1;
      wr(16'h6040, 8'h00, 32'h000F);
      st(16'h0027);
      `CHK(state_report[15], 1'b1)
      `CHK(drive_enable, 1'b1)
      for (k = 0; k < 3; k++) begin
         w = (k == 0) ? mn - 16'd5 : (k == 1) ? mx + 16'd7
            : mn + 16'($urandom % (mx - mn));
         wr(16'h6042, 8'h00, {16'h0, w});
         wt();
         rdc(16'h6043, 8'h00, sx(clamp(w)));
         `CHK(speed_demand, clamp(w))
         `CHK(state_report[11], k < 2)
      end
      op_mode = 8'h02;
      wr(16'h6040, 8'h00, 32'h010F);
      wt();
      `CHK(halt_active, 1'b1)
      rdc(16'h6043, 8'h00, 32'h0);
      wr(16'h6040, 8'h00, 32'h000B);
      st(16'h0007);
      `CHK(quick_stop_active, 1'b1)
      done("states");
      c = 16'($urandom);
      trip(c);
      st(16'h0008);
      `CHK(error_code, c)
      wr(16'h6040, 8'h00, 32'h0080);
      st(16'h0040);
      `CHK(error_code, 16'h0)
      c = 16'($urandom);
      trip(c);
      st(16'h0008);
      `CHK(error_code, c)
      wr(16'h6040, 8'h00, 32'h0000);
      wr(16'h6040, 8'h00, 32'h0080);
      st(16'h0040);
      `CHK(error_code, 16'h0)
      // sticky warning, cleared by a fresh fault-clear edge
      warn_event = 1'b1;
      wt();
      warn_event = 1'b0;
      `CHK(state_report[7], 1'b1)
      wr(16'h6040, 8'h00, 32'h0000);
      wr(16'h6040, 8'h00, 32'h0080);
      wt();
      `CHK(state_report[7], 1'b0)
      done("faults");
      // reset in mid-run brings the objects back to their presets
      reset_n = 1'b0;
      wt();
      `CHK(state_report, 16'h0000)
      reset_n = 1'b1;
      rdc(16'h6040, 8'h00, 32'h0);
      rdc(16'h6042, 8'h00, 32'h000000C8);
      done("reset");
      stop_test();
   end
endmodule

// >>> verilog/dpsc_consts.svh
// constants of the drive power state control block
// assumes inclusion by the design modules
`ifndef DPSC_CONSTS_SVH
`define DPSC_CONSTS_SVH
// object indices
`define DPSC_IDX_CMD      16'h6040
`define DPSC_IDX_STAT     16'h6041
`define DPSC_IDX_TARGET   16'h6042
`define DPSC_IDX_DEMAND   16'h6043
`define DPSC_IDX_MEASURED 16'h6044
`define DPSC_IDX_LIMIT    16'h6046
// subindices of the limit array
`define DPSC_SUB_COUNT    8'h00
`define DPSC_SUB_MIN      8'h01
`define DPSC_SUB_MAX      8'h02
`define DPSC_LIMIT_COUNT  8'h02
// reset values
`define DPSC_CMD_RST      16'h0000
`define DPSC_TARGET_RST   16'h00C8
`define DPSC_MIN_RST      32'h00000000
`define DPSC_MAX_RST      32'h00007530
// command word bit positions
`define DPSC_CB_SWITCH_ON 0
`define DPSC_CB_VOLTAGE   1
`define DPSC_CB_QSTOP_N   2
`define DPSC_CB_OPERATE   3
`define DPSC_CB_MODE_LO   4
`define DPSC_CB_FAULT_CLR 7
`define DPSC_CB_HALT      8
`define DPSC_CB_MODE_HI   9
// status word bit positions
`define DPSC_SB_READY     0
`define DPSC_SB_SW_ON     1
`define DPSC_SB_OP_EN     2
`define DPSC_SB_FAULT     3
`define DPSC_SB_VOLTAGE   4
`define DPSC_SB_QSTOP_N   5
`define DPSC_SB_SOD       6
`define DPSC_SB_WARN      7
`define DPSC_SB_SYNC      8
`define DPSC_SB_REMOTE    9
`define DPSC_SB_GOAL      10
`define DPSC_SB_LIMIT     11
`define DPSC_SB_MODE_LO   12
`define DPSC_SB_CLOSED    15
// operating mode codes
`define DPSC_MODE_PPOS    8'h01
`define DPSC_MODE_VEL     8'h02
`define DPSC_MODE_PVEL    8'h03
`define DPSC_MODE_PTRQ    8'h04
`define DPSC_MODE_IPOS    8'h07
`endif

// >>> verilog/dpsc_decode.sv
// decodes the command word into requests for the state machine
// assumes the command word is a registered value
`timescale 1ns/10ps
`include "dpsc_consts.svh"
module dpsc_decode
   import dpsc_pkg::*;
(
   // command and mode
   input  wire logic [15:0] cmd,
   input  wire logic [7:0]  mode,
   // decoded requests
   output logic             shutdown,
   output logic             switch_on,
   output logic             enable_op,
   output logic             disable_volt,
   output logic             quick_stop,
   output logic             halt,
   output logic [3:0]       mode_dependent_bits
);
   // true for modes where halt is honoured
   function automatic logic halt_mode(input logic [7:0] m);
      halt_mode = (m == `DPSC_MODE_PPOS) || (m == `DPSC_MODE_VEL) ||
                  (m == `DPSC_MODE_PVEL) || (m == `DPSC_MODE_PTRQ) ||
                  (m == `DPSC_MODE_IPOS);
   endfunction
   wire logic switch_on_request;
   wire logic enable_voltage_request;
   wire logic quick_stop_request_n;
   wire logic enable_operation_request;
   assign switch_on_request        = cmd[`DPSC_CB_SWITCH_ON];
   assign enable_voltage_request   = cmd[`DPSC_CB_VOLTAGE];
   assign quick_stop_request_n     = cmd[`DPSC_CB_QSTOP_N];
   assign enable_operation_request = cmd[`DPSC_CB_OPERATE];
   // power requests
   assign disable_volt = ~enable_voltage_request;
   assign quick_stop   = enable_voltage_request &
                         ~quick_stop_request_n;
   assign shutdown     = enable_voltage_request & quick_stop_request_n &
                         ~switch_on_request;
   assign switch_on    = enable_voltage_request & quick_stop_request_n &
                         switch_on_request;
   assign enable_op    = switch_on & enable_operation_request;
   assign halt = cmd[`DPSC_CB_HALT] & halt_mode(mode);
   // mode bits pass only while a mode is selected
   assign mode_dependent_bits = (mode == 8'h00) ? 4'h0 :
      {cmd[`DPSC_CB_MODE_HI], cmd[`DPSC_CB_MODE_LO+2:`DPSC_CB_MODE_LO]};
endmodule

// >>> verilog/dpsc_limit.sv
// clamps the signed target speed into the min/max window
// assumes limits are unsigned 32-bit values in user units
`timescale 1ns/10ps
`include "dpsc_consts.svh"
module dpsc_limit
   import dpsc_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // request
   input  wire logic signed [WIDTH-1:0] target,
   input  wire logic        [31:0]      min_limit,
   input  wire logic        [31:0]      max_limit,
   // result
   output logic signed [WIDTH-1:0]      clamped,
   output logic                         limited
);
   // compare as 33-bit signed so huge limits never wrap negative
   wire logic signed [32:0] tgt_ext;
   wire logic signed [32:0] min_ext;
   wire logic signed [32:0] max_ext;
   wire logic               below;
   wire logic               above;
   assign tgt_ext = 33'(target);
   assign min_ext = $signed({1'b0, min_limit});
   assign max_ext = $signed({1'b0, max_limit});
   assign below   = tgt_ext < min_ext;
   assign above   = tgt_ext > max_ext;
   // replace out-of-range speeds by the violated bound
   assign clamped = below ? WIDTH'(min_limit) :
                    above ? WIDTH'(max_limit) : target;
   assign limited = below | above;
endmodule

// >>> verilog/dpsc_pkg.sv
// types of the drive power state control block
// assumes the constants header sits beside it
package dpsc_pkg;
   typedef enum logic [2:0] {
      DPSC_NOT_READY = 3'b000,
      DPSC_SOD       = 3'b001,
      DPSC_READY     = 3'b010,
      DPSC_SWITCHED  = 3'b011,
      DPSC_OPERATE   = 3'b100,
      DPSC_QSTOP     = 3'b101,
      DPSC_FREACT    = 3'b110,
      DPSC_FAULT     = 3'b111
   } dpsc_state_t;
endpackage

// >>> verilog/dpsc_top.sv
// drive power state control: object store, state machine, status
// assumes a fieldbus stack presents object index/subindex accesses
// that complete in one cycle; inputs are synchronous to clk
`timescale 1ns/10ps
`include "dpsc_consts.svh"
module dpsc_top
   import dpsc_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   // object access from the fieldbus stack
   input  wire logic                    obj_wr,
   input  wire logic                    obj_rd,
   input  wire logic [15:0]             obj_index,
   input  wire logic [7:0]              obj_sub,
   input  wire logic [31:0]             obj_wdata,
   output logic      [31:0]             obj_rdata,
   output logic                         obj_ack,
   output logic                         obj_err,
   // drive side status
   input  wire logic [7:0]              op_mode,
   input  wire logic                    special_mode,
   input  wire logic                    bus_synced,
   input  wire logic                    closed_loop,
   input  wire logic                    fault_event,
   input  wire logic [15:0]             fault_code,
   input  wire logic                    warn_event,
   input  wire logic                    reaction_done,
   input  wire logic                    goal_reached,
   input  wire logic                    init_done,
   input  wire logic signed [WIDTH-1:0] speed_measured,
   // drive side control
   output logic                         power_enable,
   output logic                         drive_enable,
   output logic                         quick_stop_active,
   output logic                         halt_active,
   output logic [3:0]                   mode_dependent_bits,
   output logic signed [WIDTH-1:0]      speed_demand,
   output logic [15:0]                  error_code,
   output logic [15:0]                  state_report
);
   // registers
   logic        [15:0]      cmd_ff;
   logic signed [WIDTH-1:0] target_ff;
   logic        [31:0]      min_ff;
   logic        [31:0]      max_ff;
   logic signed [WIDTH-1:0] demand_ff;
   logic signed [WIDTH-1:0] measured_ff;
   logic        [15:0]      err_ff;
   logic        [15:0]      stat_ff;
   logic                    warn_ff;
   logic                    fclr_prev_ff;
   logic        [31:0]      rdata_ff;
   logic                    ack_ff;
   logic                    err_acc_ff;
   dpsc_state_t             state_ff;
   dpsc_state_t             nxt_state;

   // decoder and limiter outputs
   logic                    req_shutdown;
   logic                    req_switch_on;
   logic                    req_enable_op;
   logic                    req_disable_volt;
   logic                    req_quick_stop;
   logic                    req_halt;
   logic [3:0]              mode_bits;
   logic signed [WIDTH-1:0] target_clamped;
   logic                    limited;

   dpsc_decode u_decode (
      .cmd                 (cmd_ff),
      .mode                (op_mode),
      .shutdown            (req_shutdown),
      .switch_on           (req_switch_on),
      .enable_op           (req_enable_op),
      .disable_volt        (req_disable_volt),
      .quick_stop          (req_quick_stop),
      .halt                (req_halt),
      .mode_dependent_bits (mode_bits)
   );

   dpsc_limit #(
      .WIDTH (WIDTH)
   ) u_limit (
      .target    (target_ff),
      .min_limit (min_ff),
      .max_limit (max_ff),
      .clamped   (target_clamped),
      .limited   (limited)
   );

   // object address decode
   wire logic hit_cmd;
   wire logic hit_stat;
   wire logic hit_target;
   wire logic hit_demand;
   wire logic hit_meas;
   wire logic hit_lim;
   wire logic hit_min;
   wire logic hit_max;
   wire logic hit_cnt;
   wire logic known;
   wire logic writable;
   assign hit_cmd    = obj_index == `DPSC_IDX_CMD;
   assign hit_stat   = obj_index == `DPSC_IDX_STAT;
   assign hit_target = obj_index == `DPSC_IDX_TARGET;
   assign hit_demand = obj_index == `DPSC_IDX_DEMAND;
   assign hit_meas   = obj_index == `DPSC_IDX_MEASURED;
   assign hit_lim    = obj_index == `DPSC_IDX_LIMIT;
   assign hit_cnt    = hit_lim & (obj_sub == `DPSC_SUB_COUNT);
   assign hit_min    = hit_lim & (obj_sub == `DPSC_SUB_MIN);
   assign hit_max    = hit_lim & (obj_sub == `DPSC_SUB_MAX);
   assign known      = hit_cmd | hit_stat | hit_target | hit_demand |
                       hit_meas | hit_cnt | hit_min | hit_max;
   // status, demand, measured and the count are read-only
   assign writable   = hit_cmd | hit_target | hit_min | hit_max;

   wire logic wr_ok;
   assign wr_ok = obj_wr & writable;

   // fault clear acts on a rising edge of the command bit only
   wire logic fclr_edge;
   assign fclr_edge = cmd_ff[`DPSC_CB_FAULT_CLR] & ~fclr_prev_ff;

   // power state machine transitions
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         DPSC_NOT_READY: begin
            if (init_done)
               nxt_state = DPSC_SOD;
         end
         DPSC_SOD: begin
            if (req_shutdown)
               nxt_state = DPSC_READY;
         end
         DPSC_READY: begin
            if (req_disable_volt | req_quick_stop)
               nxt_state = DPSC_SOD;
            else if (req_switch_on)
               nxt_state = DPSC_SWITCHED;
         end
         DPSC_SWITCHED: begin
            if (req_disable_volt | req_quick_stop)
               nxt_state = DPSC_SOD;
            else if (req_shutdown)
               nxt_state = DPSC_READY;
            else if (req_enable_op)
               nxt_state = DPSC_OPERATE;
         end
         DPSC_OPERATE: begin
            if (req_disable_volt)
               nxt_state = DPSC_SOD;
            else if (req_quick_stop)
               nxt_state = DPSC_QSTOP;
            else if (req_shutdown)
               nxt_state = DPSC_READY;
            else if (!req_enable_op)
               nxt_state = DPSC_SWITCHED;
         end
         DPSC_QSTOP: begin
            if (req_disable_volt)
               nxt_state = DPSC_SOD;
            else if (req_enable_op)
               nxt_state = DPSC_OPERATE;
         end
         DPSC_FREACT: begin
            if (reaction_done)
               nxt_state = DPSC_FAULT;
         end
         DPSC_FAULT: begin
            if (fclr_edge)
               nxt_state = DPSC_SOD;
         end
         default: nxt_state = DPSC_NOT_READY;
      endcase
      // a new fault overrides any request outside the fault path
      if (fault_event && state_ff != DPSC_FREACT &&
          state_ff != DPSC_FAULT)
         nxt_state = DPSC_FREACT;
   end

   // state code on bits 6,5,3..0
   wire logic [15:0] state_bits;
   assign state_bits[`DPSC_SB_READY] = state_ff == DPSC_READY ||
      state_ff == DPSC_SWITCHED || state_ff == DPSC_OPERATE ||
      state_ff == DPSC_QSTOP || state_ff == DPSC_FREACT;
   assign state_bits[`DPSC_SB_SW_ON] = state_ff == DPSC_SWITCHED ||
      state_ff == DPSC_OPERATE || state_ff == DPSC_QSTOP ||
      state_ff == DPSC_FREACT;
   assign state_bits[`DPSC_SB_OP_EN] = state_ff == DPSC_OPERATE ||
      state_ff == DPSC_QSTOP || state_ff == DPSC_FREACT;
   assign state_bits[`DPSC_SB_FAULT] = state_ff == DPSC_FREACT ||
      state_ff == DPSC_FAULT;
   assign state_bits[`DPSC_SB_VOLTAGE] = state_ff == DPSC_READY ||
      state_ff == DPSC_SWITCHED || state_ff == DPSC_OPERATE ||
      state_ff == DPSC_QSTOP;
   assign state_bits[`DPSC_SB_QSTOP_N] = state_ff == DPSC_READY ||
      state_ff == DPSC_SWITCHED || state_ff == DPSC_OPERATE;
   assign state_bits[`DPSC_SB_SOD] = state_ff == DPSC_SOD;
   assign state_bits[`DPSC_SB_WARN] = warn_ff;
   assign state_bits[`DPSC_SB_SYNC] = bus_synced;
   assign state_bits[`DPSC_SB_REMOTE] = ~special_mode;
   assign state_bits[`DPSC_SB_GOAL] = goal_reached;
   assign state_bits[`DPSC_SB_LIMIT] = limited;
   assign state_bits[14:12] = {1'b0, mode_bits[1:0]};
   assign state_bits[`DPSC_SB_CLOSED] =
      (state_ff == DPSC_OPERATE) & closed_loop;

   // demand follows the clamped target only while operating and not halted
   wire logic signed [WIDTH-1:0] nxt_demand;
   assign nxt_demand = (state_ff == DPSC_OPERATE && !req_halt) ?
                       target_clamped : '0;

   // read mux
   wire logic [31:0] nxt_rdata;
   assign nxt_rdata =
      hit_cmd    ? {16'h0000, cmd_ff} :
      hit_stat   ? {16'h0000, stat_ff} :
      hit_target ? {{(32-WIDTH){target_ff[WIDTH-1]}}, target_ff} :
      hit_demand ? {{(32-WIDTH){demand_ff[WIDTH-1]}}, demand_ff} :
      hit_meas   ? {{(32-WIDTH){measured_ff[WIDTH-1]}}, measured_ff} :
      hit_cnt    ? {24'h000000, `DPSC_LIMIT_COUNT} :
      hit_min    ? min_ff :
      hit_max    ? max_ff : 32'h00000000;

   // state and edge history
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff     <= DPSC_NOT_READY;
         fclr_prev_ff <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         fclr_prev_ff <= cmd_ff[`DPSC_CB_FAULT_CLR];
      end
   end

   // writable objects
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cmd_ff    <= `DPSC_CMD_RST;
         target_ff <= WIDTH'(`DPSC_TARGET_RST);
         min_ff    <= `DPSC_MIN_RST;
         max_ff    <= `DPSC_MAX_RST;
      end else begin
         if (wr_ok && hit_cmd)
            cmd_ff <= obj_wdata[15:0];
         if (wr_ok && hit_target)
            target_ff <= obj_wdata[WIDTH-1:0];
         if (wr_ok && hit_min)
            min_ff <= obj_wdata;
         if (wr_ok && hit_max)
            max_ff <= obj_wdata;
      end
   end

   // error code and warning: a new event wins over a clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         err_ff  <= 16'h0000;
         warn_ff <= 1'b0;
      end else begin
         if (fault_event)
            err_ff <= fault_code;
         else if (fclr_edge && state_ff == DPSC_FAULT)
            err_ff <= 16'h0000;
         if (warn_event)
            warn_ff <= 1'b1;
         else if (fclr_edge)
            warn_ff <= 1'b0;
      end
   end

   // read-only objects and the status word
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stat_ff     <= 16'h0000;
         demand_ff   <= '0;
         measured_ff <= '0;
      end else begin
         stat_ff     <= state_bits;
         demand_ff   <= nxt_demand;
         measured_ff <= speed_measured;
      end
   end

   // one-cycle access answer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_ff   <= 32'h00000000;
         ack_ff     <= 1'b0;
         err_acc_ff <= 1'b0;
      end else begin
         rdata_ff   <= obj_rd ? nxt_rdata : rdata_ff;
         ack_ff     <= obj_rd | obj_wr;
         err_acc_ff <= (obj_rd & ~known) | (obj_wr & ~writable);
      end
   end

   // outputs
   assign obj_rdata           = rdata_ff;
   assign obj_ack             = ack_ff;
   assign obj_err             = err_acc_ff;
   assign power_enable        = stat_ff[`DPSC_SB_VOLTAGE];
   assign drive_enable        = stat_ff[`DPSC_SB_OP_EN] &
                                stat_ff[`DPSC_SB_QSTOP_N];
   assign quick_stop_active   = state_ff == DPSC_QSTOP;
   assign halt_active         = req_halt;
   assign mode_dependent_bits = mode_bits;
   assign speed_demand        = demand_ff;
   assign error_code          = err_ff;
   assign state_report        = stat_ff;
endmodule
